// ==== logic/pdc_ctrl.sv ====
// controller driving a seven-bit programmable delay line
`timescale 1ns/1ps
// Overview of operation
// - Gating pins held low normally, both always driven alike.
// - Code is captured in registers, so it is held stable.
// - Wait step times code increase after last true edge before code change.
// - Disable while active: gate high, source low for code times step.
// - Source period at least 200% and width 100% of full range.
// - Output needs period at least 16% and width 8% of full range.
module pdc_ctrl #(
  parameter int unsigned STEP_PS = pdc_pkg::STEP_DELAY_PS,
  parameter int unsigned INH_PS = pdc_pkg::INHERENT_DELAY_PS
) (
  input wire logic mclk, // 10 MHz clock
  input wire logic srst, // sync reset, active high
  input wire logic pulse_req, // request one source pulse
  input wire logic code_req, // request code change
  input wire logic [6:0] code_new, // requested code
  input wire logic dis_req, // request disable and clear
  input wire logic en_req, // request re-enable
  input wire logic dly_out, // true output pin from device
  output logic busy, // controller not idle
  output logic enabled, // outputs currently enabled
  output logic [6:0] delay_select_code, // code pins
  output logic gate_n, // both gating pins
  output logic src // source pin
);
  localparam int unsigned CW = pdc_pkg::CNT_W;
  localparam int unsigned FULL_PS = pdc_pkg::CODE_STEPS * STEP_PS;

  // round a picosecond figure up to cycles, at least one
  function automatic logic [CW-1:0] ps2cyc(input int unsigned ps);
    int unsigned c;
    c = (ps + pdc_pkg::CLK_PERIOD_PS - 1) / pdc_pkg::CLK_PERIOD_PS;
    if (c == 0)
      c = 1;
    return c[CW-1:0];
  endfunction

  localparam logic [CW-1:0] HI_CYC = ps2cyc(FULL_PS * pdc_pkg::WIDTH_MIN_PCT / 100);
  localparam logic [CW-1:0] LO_CYC = ps2cyc(FULL_PS * (pdc_pkg::PERIOD_MIN_PCT - pdc_pkg::WIDTH_MIN_PCT) / 100);
  localparam logic [CW-1:0] DRAIN_CYC = ps2cyc(INH_PS + FULL_PS);

  pdc_pkg::pdc_state_t st_q;
  logic [6:0] code_q;
  logic [6:0] pend_q;
  logic gate_q;
  logic src_q;
  logic out_s1_q;
  logic out_s2_q;
  logic out_prev_q;
  logic ld;
  logic [CW-1:0] ld_cyc;
  logic tdone;

  pdc_wait_timer #(.W(CW)) u_tmr (
    .mclk(mclk),
    .srst(srst),
    .load(ld),
    .cycles(ld_cyc),
    .done(tdone)
  );

  // two-stage sync of the device output pin
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      out_s1_q <= 1'b0;
      out_s2_q <= 1'b0;
      out_prev_q <= 1'b0;
    end
    else
    begin
      out_s1_q <= dly_out;
      out_s2_q <= out_s1_q;
      out_prev_q <= out_s2_q;
    end
  end

  // step wait in cycles for a code change or a clear
  function automatic logic [CW-1:0] step_cyc(input logic [6:0] steps);
    return ps2cyc(int'(steps) * STEP_PS);
  endfunction

  always_comb
  begin
    ld = 1'b0;
    ld_cyc = '0;
    case (st_q)
      pdc_pkg::ST_IDLE:
      begin
        if (dis_req && gate_q == 1'b0)
        begin
          ld = 1'b1;
          ld_cyc = step_cyc(code_q);
        end
        else if (pulse_req && !gate_q)
        begin
          ld = 1'b1;
          ld_cyc = HI_CYC;
        end
        else if (code_req)
        begin
          ld = 1'b1;
          ld_cyc = DRAIN_CYC;
        end
      end
      pdc_pkg::ST_PULSE_HI:
      begin
        if (tdone)
        begin
          ld = 1'b1;
          ld_cyc = LO_CYC;
        end
      end
      pdc_pkg::ST_DRAIN:
      begin
        // last true edge seen, or full delay passed: start code-change wait
        if (tdone || (out_s2_q != out_prev_q))
        begin
          ld = 1'b1;
          ld_cyc = (pend_q > code_q) ? step_cyc(7'(pend_q - code_q)) : 16'h0001;
        end
      end
      default:
      begin
        ld = 1'b0;
        ld_cyc = '0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      st_q <= pdc_pkg::ST_IDLE;
    else
    begin
      case (st_q)
        pdc_pkg::ST_IDLE:
        begin
          if (dis_req && !gate_q)
            st_q <= pdc_pkg::ST_DIS_HOLD;
          else if (pulse_req && !gate_q)
            st_q <= pdc_pkg::ST_PULSE_HI;
          else if (code_req)
            st_q <= pdc_pkg::ST_DRAIN;
        end
        pdc_pkg::ST_PULSE_HI:
          if (tdone)
            st_q <= pdc_pkg::ST_PULSE_LO;
        pdc_pkg::ST_PULSE_LO:
          if (tdone)
            st_q <= pdc_pkg::ST_IDLE;
        pdc_pkg::ST_DRAIN:
          if (tdone || (out_s2_q != out_prev_q))
            st_q <= pdc_pkg::ST_CODE_WAIT;
        pdc_pkg::ST_CODE_WAIT:
          if (tdone)
            st_q <= pdc_pkg::ST_IDLE;
        pdc_pkg::ST_DIS_HOLD:
          if (tdone)
            st_q <= pdc_pkg::ST_IDLE;
        default:
          st_q <= pdc_pkg::ST_IDLE;
      endcase
    end
  end

  // code held stable except at the end of the code-change wait
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      code_q <= pdc_pkg::CODE_RESET;
      pend_q <= pdc_pkg::CODE_RESET;
    end
    else
    begin
      if (st_q == pdc_pkg::ST_IDLE && code_req && !(dis_req && !gate_q) && !(pulse_req && !gate_q))
        pend_q <= code_new;
      if (st_q == pdc_pkg::ST_CODE_WAIT && tdone)
        code_q <= pend_q;
    end
  end

  // gating pins: one register drives both, low while enabled
  always_ff @(posedge mclk)
  begin
    if (srst)
      gate_q <= 1'b0;
    else if (st_q == pdc_pkg::ST_IDLE && dis_req && !gate_q)
      gate_q <= 1'b1;
    else if (st_q == pdc_pkg::ST_IDLE && en_req && !dis_req)
      gate_q <= 1'b0;
  end

  // source pulse, forced low while disabling
  always_ff @(posedge mclk)
  begin
    if (srst)
      src_q <= 1'b0;
    else if (st_q == pdc_pkg::ST_IDLE && pulse_req && !gate_q && !dis_req)
      src_q <= 1'b1;
    else if (st_q == pdc_pkg::ST_PULSE_HI && tdone)
      src_q <= 1'b0;
    else if (st_q == pdc_pkg::ST_DIS_HOLD)
      src_q <= 1'b0;
  end

  assign delay_select_code = code_q;
  assign gate_n = gate_q;
  assign src = src_q;
  assign busy = (st_q != pdc_pkg::ST_IDLE);
  assign enabled = !gate_q;
endmodule // pdc_ctrl

// ==== logic/pdc_pkg.sv ====
// package: timing constants and states for the delay line controller
package pdc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 100000;
  localparam int unsigned STEP_DELAY_PS = 1000;
  localparam int unsigned INHERENT_DELAY_PS = 13000;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned CODE_STEPS = 127;
  localparam int unsigned FULL_RANGE_DELAY_PS = CODE_STEPS * STEP_DELAY_PS;
  localparam int unsigned CNT_W = 16;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam int unsigned PERIOD_MIN_PCT = 200;
  localparam int unsigned WIDTH_MIN_PCT = 100;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PULSE_HI = 3'b001,
    ST_PULSE_LO = 3'b010,
    ST_DRAIN = 3'b011,
    ST_CODE_WAIT = 3'b100,
    ST_DIS_HOLD = 3'b101
  } pdc_state_t;
endpackage

// ==== logic/pdc_wait_timer.sv ====
// cycle count-down timer for wait intervals
`timescale 1ns/1ps
module pdc_wait_timer #(
  parameter int unsigned W = 16
) (
  input wire logic mclk, // clock
  input wire logic srst, // sync reset
  input wire logic load, // start pulse
  input wire logic [W-1:0] cycles, // cycles to wait
  output logic done // high when idle or expired
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= cycles;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
  // no term from load here: the caller derives load from done, so it would close a loop
  assign done = (cnt_q == '0);
endmodule // pdc_wait_timer

// ==== tb/pdc_dev_model.sv ====
// behavioural model of the seven-bit delay line
`timescale 1ns/1ps
module pdc_dev_model #(
  parameter real STEP_NS = 1.0,
  parameter real INH_NS = 13.0
) (
  input wire logic gate_n, // both gating pins
  input wire logic src, // source pin
  input wire logic [6:0] code, // select code pins
  output logic dly_out, // true output
  output logic dly_n // complement output
);
  logic dly_q = 1'b0;
  logic spur_q = 1'b0;
  logic [6:0] code_old;
  real t_src = 0.0;
  // transport delay, grows with code so never shrinks as code rises
  always @(src)
  begin
    t_src = $realtime;
    dly_q <= #(INH_NS + STEP_NS * code) src;
  end
  // code moved while an edge is still in flight: short false pulse on the true output
  always @(code)
  begin
    if (!$isunknown(code_old) && $realtime < t_src + INH_NS + STEP_NS * code_old)
    begin
      spur_q = 1'b1;
      #1 spur_q = 1'b0;
    end
    code_old = code;
  end
  assign dly_out = gate_n ? 1'b0 : (dly_q | spur_q);
  assign dly_n = gate_n ? 1'b1 : ~dly_q;
endmodule // pdc_dev_model

// ==== tb/pdc_ctrl_monitor.sv ====
// port assertions for the delay line controller
`timescale 1ns/1ps
module pdc_ctrl_monitor (
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire logic pulse_req, // pulse request
  input wire logic code_req, // code request
  input wire logic dis_req, // disable request
  input wire logic busy, // busy
  input wire logic enabled, // enabled
  input wire logic [6:0] delay_select_code, // code pins
  input wire logic gate_n, // gating pins
  input wire logic src // source pin
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_gate_rise_dis: assert property ($rose(gate_n) |-> $past(dis_req) && !$past(busy)) else $error("gate rose alone");
  a_code_still_src: assert property (src |-> $stable(delay_select_code)) else $error("code moved");
  a_code_when_busy: assert property ($changed(delay_select_code) |-> $past(busy)) else $error("code idle");
  a_code_req_take: assert property (!busy && code_req && !dis_req && !pulse_req |=> busy) else $error("no take");
  a_dis_take: assert property (!busy && enabled && dis_req |=> gate_n && busy) else $error("no disable");
  a_src_low_gated: assert property (gate_n |-> !src) else $error("source high while gated");
  a_pulse_width_min: assert property ($rose(src) |-> src[*2]) else $error("pulse too short");
  a_pulse_gap_min: assert property ($fell(src) |-> !src[*2]) else $error("gap too short");
  a_dis_hold_min: assert property ($rose(gate_n) |-> gate_n[*2]) else $error("disable too short");
  cover property ($rose(src));
  cover property ($changed(delay_select_code));
  cover property ($fell(gate_n));
endmodule // pdc_ctrl_monitor
bind pdc_ctrl pdc_ctrl_monitor i_pdc_ctrl_monitor (.mclk(mclk), .srst(srst), .pulse_req(pulse_req),
  .code_req(code_req), .dis_req(dis_req), .busy(busy), .enabled(enabled),
  .delay_select_code(delay_select_code), .gate_n(gate_n), .src(src));

// ==== tb/tb_pdc_ctrl.sv ====
// self-checking bench for the delay line controller
`timescale 1ns/1ps
module tb_pdc_ctrl;
  logic mclk = 1'b0, srst = 1'b1, pulse_req = 1'b0, code_req = 1'b0, dis_req = 1'b0, en_req = 1'b0;
  logic [6:0] code_new = 7'h00, code;
  logic busy, enabled, gate_n, src, dly_out, dly_n;
  int err_total = 0, tests_run = 0, rises = 0;
  always #50 mclk = ~mclk;
  always @(posedge dly_out) rises++;
  pdc_ctrl #(.STEP_PS(1000), .INH_PS(13000)) i_pdc_ctrl (.mclk(mclk), .srst(srst), .pulse_req(pulse_req),
    .code_req(code_req), .code_new(code_new), .dis_req(dis_req), .en_req(en_req), .dly_out(dly_out),
    .busy(busy), .enabled(enabled), .delay_select_code(code), .gate_n(gate_n), .src(src));
  pdc_dev_model i_pdc_dev_model (.gate_n(gate_n), .src(src), .code(code), .dly_out(dly_out), .dly_n(dly_n));
  task automatic go();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      go();
      n++;
    end
    if (n >= 4000)
    begin
      err_total++;
      complete_run();
    end
  endtask
  // src rose at the last edge, one ns ago
  task automatic pulse(logic [6:0] c);
    pulse_req = 1'b1;
    go();
    pulse_req = 1'b0;
    chk("src high", 8'(src), 8'h01);
    #(11 + c);
    chk("early", 8'({dly_out, dly_n}), 8'h01);
    #3;
    chk("late", 8'({dly_out, dly_n}), 8'h02);
    wait_idle();
    chk("code", 8'(code), 8'(c));
  endtask
  task automatic set_code(logic [6:0] c);
    int r0 = rises;
    code_req = 1'b1;
    code_new = c;
    go();
    code_req = 1'b0;
    go();
    chk("busy", 8'(busy), 8'h01);
    wait_idle();
    chk("new code", 8'(code), 8'(c));
    chk("spurious", 8'(rises - r0), 8'h00);
  endtask
  // pulse request held across the hold and into idle: must be refused while gated
  task automatic off_on();
    dis_req = 1'b1;
    go();
    dis_req = 1'b0;
    pulse_req = 1'b1;
    go();
    chk("gated", 8'({gate_n, enabled}), 8'h02);
    wait_idle();
    go();
    chk("refused src", 8'(src), 8'h00);
    chk("refused busy", 8'(busy), 8'h00);
    pulse_req = 1'b0;
    en_req = 1'b1;
    go();
    en_req = 1'b0;
    go();
    chk("ungated", 8'({gate_n, enabled}), 8'h01);
  endtask
  // reset lands in the middle of a code change
  task automatic mid_reset();
    code_req = 1'b1;
    code_new = 7'h40;
    go();
    code_req = 1'b0;
    srst = 1'b1;
    go();
    srst = 1'b0;
    chk("mid reset busy", 8'(busy), 8'h00);
    chk("mid reset pins", 8'({src, code}), 8'h00);
    chk("mid reset gate", 8'({gate_n, enabled}), 8'h01);
  endtask
  initial
  begin
    repeat (16) go();
    srst = 1'b0;
    chk("reset pins", 8'({src, code}), 8'h00);
    chk("reset gate", 8'({gate_n, enabled}), 8'h01);
    pulse(7'h00);
    set_code(7'h05);
    pulse(7'h05);
    set_code(7'h7f);
    pulse(7'h7f);
    mid_reset();
    off_on();
    set_code(7'h02);
    pulse(7'h02);
    complete_run();
  end
endmodule // tb_pdc_ctrl
